// ==== hw/cascade_timer_defs.vh ====
`ifndef CASCADE_TIMER_DEFS_VH
`define CASCADE_TIMER_DEFS_VH
// apb register byte addresses
`define ADDR_CONFIG 12'h000
`define ADDR_MODE 12'h004
`define ADDR_CTRL 12'h008
`define ADDR_LOW_COUNT 12'h00c
`define ADDR_HIGH_COUNT 12'h010
`define ADDR_POWER 12'h014
`define ADDR_STATUS 12'h018
// config register bits
`define CFG_WATCHDOG 7
`define CFG_CASCADE 6
// mode register fields
`define MODE_LOW_SRC 2
`define MODE_LOW_M_HI 1
`define MODE_LOW_M_LO 0
`define MODE_HIGH_SRC 6
`define MODE_HIGH_M_HI 5
`define MODE_HIGH_M_LO 4
// control register bits
`define CTRL_LOW_RUN 4
`define CTRL_LOW_FLAG 5
`define CTRL_HIGH_RUN 6
`define CTRL_HIGH_FLAG 7
// power control bit
`define PWR_DOWN 1
// machine cycle phases, 12 clocks per machine cycle
`define PHASE_LAST 4'hb
`define PHASE_STATE3_PHASE1 4'h4
`define PHASE_STATE5_PHASE1 4'h8
`define PHASE_STATE5_PHASE2 4'h9
// timer modes
`define TMODE_13 2'h0
`define TMODE_16 2'h1
`define TMODE_RELOAD 2'h2
`define TMODE_SPLIT 2'h3
// reset values
`define RST_BYTE 8'h00
`define RST_SP 8'h07
`define RST_PORT 8'hff
`define WD_RESET_CYCLES 3'h5
`endif

// ==== hw/cascaded_timer_watchdog.v ====
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "cascade_timer_defs.vh"
module cascaded_timer_watchdog (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // count inputs
  input wire lowCountInput,
  input wire highCountInput,
  // chip side
  output reg chipReset,
  output reg lowTimerInterrupt,
  output reg highTimerInterrupt,
  output reg [7:0] stackPointerReset,
  output reg [7:0] portLatchReset
);
  reg [7:0] configReg;
  reg [7:0] modeReg;
  reg [7:0] ctrlReg;
  reg [7:0] powerReg;
  reg [15:0] lowCount;
  reg [15:0] highCount;
  reg [7:0] lowReload;
  reg [7:0] highReload;
  reg [2:0] resetCycles;
  reg resetPending;
  wire state3_phase1;
  wire state5_phase1;
  wire state5_phase2;
  wire cycleEnd;
  wire lowFall;
  wire highFall;
  wire apbWrite = psel & penable & pwrite;
  wire cascade = configReg[`CFG_CASCADE];
  wire watchdog = configReg[`CFG_WATCHDOG];
  wire lowSrc = modeReg[`MODE_LOW_SRC];
  wire highSrc = modeReg[`MODE_HIGH_SRC];
  wire [1:0] lowMode = modeReg[`MODE_LOW_M_HI:`MODE_LOW_M_LO];
  wire [1:0] highMode = modeReg[`MODE_HIGH_M_HI:`MODE_HIGH_M_LO];
  wire lowRun = ctrlReg[`CTRL_LOW_RUN];
  wire highRun = ctrlReg[`CTRL_HIGH_RUN];
  wire lowFlag = ctrlReg[`CTRL_LOW_FLAG];
  wire highFlag = ctrlReg[`CTRL_HIGH_FLAG];
  machine_cycle cycleGen (
    .clock(clock),
    .sys_rst(sys_rst),
    .strobeS3P1(state3_phase1),
    .strobeS5P1(state5_phase1),
    .strobeS5P2(state5_phase2),
    .cycleEnd(cycleEnd)
  );
  // one sampler per count input
  wire [1:0] countPins = {highCountInput, lowCountInput};
  wire [1:0] fallEvents;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_sampler
      event_sampler u_sampler (
        .clock(clock),
        .sys_rst(sys_rst),
        .sampleStrobe(state5_phase2),
        .pin(countPins[ch]),
        .fallEvent(fallEvents[ch])
      );
    end
  endgenerate
  assign lowFall = fallEvents[0];
  assign highFall = fallEvents[1];
  // count ticks; events latched until next state3_phase1
  reg lowEvtHeld;
  reg highEvtHeld;
  wire powerDown = powerReg[`PWR_DOWN];
  wire lowTick = state3_phase1 & (lowSrc ? lowEvtHeld : ~powerDown);
  wire highTick = state3_phase1 & (highSrc ? highEvtHeld : ~powerDown);
  wire casTick = state3_phase1 & (lowSrc ? lowEvtHeld : ~powerDown);
  // next counter values
  reg [15:0] next_lowCount;
  reg [15:0] next_highCount;
  reg lowOvf;
  reg highOvf;
  always @* begin
    next_lowCount = lowCount;
    next_highCount = highCount;
    lowOvf = 1'b0;
    highOvf = 1'b0;
    if (cascade) begin
      if (casTick) begin
        {lowOvf, next_lowCount} = {1'b0, lowCount} + 17'h1;
        if (lowOvf) begin
          {highOvf, next_highCount} = {1'b0, highCount} + 17'h1;
        end
        lowOvf = 1'b0;
      end
    end else begin
      if (lowTick & lowRun) begin
        case (lowMode)
          `TMODE_13: begin
            next_lowCount = {3'h0, lowCount[12:0] + 13'h1};
            lowOvf = &lowCount[12:0];
          end
          `TMODE_16: begin
            {lowOvf, next_lowCount} = {1'b0, lowCount} + 17'h1;
          end
          `TMODE_RELOAD: begin
            lowOvf = &lowCount[7:0];
            next_lowCount = {8'h0, lowOvf ? lowReload : lowCount[7:0] + 8'h1};
          end
          `TMODE_SPLIT: begin
            lowOvf = &lowCount[7:0];
            next_lowCount = {lowCount[15:8], lowCount[7:0] + 8'h1};
          end
          default: begin
            next_lowCount = lowCount;
          end
        endcase
      end
      // split mode: upper byte counts cycles and owns the high flag
      if (lowMode == `TMODE_SPLIT) begin
        if (state3_phase1 & ~powerDown & highRun) begin
          highOvf = &lowCount[15:8];
          next_lowCount = {lowCount[15:8] + 8'h1, next_lowCount[7:0]};
        end
      end else if (highTick & highRun) begin
        case (highMode)
          `TMODE_13: begin
            next_highCount = {3'h0, highCount[12:0] + 13'h1};
            highOvf = &highCount[12:0];
          end
          `TMODE_16: begin
            {highOvf, next_highCount} = {1'b0, highCount} + 17'h1;
          end
          `TMODE_RELOAD: begin
            highOvf = &highCount[7:0];
            next_highCount = {8'h0, highOvf ? highReload : highCount[7:0] + 8'h1};
          end
          default: begin
            next_highCount = highCount;
          end
        endcase
      end
    end
  end
  // pending overflow raised at state5_phase1
  reg lowOvfHeld;
  reg highOvfHeld;
  wire wdFire = watchdog & highOvfHeld & state5_phase1;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      configReg <= `RST_BYTE;
      modeReg <= `RST_BYTE;
      ctrlReg <= `RST_BYTE;
      powerReg <= `RST_BYTE;
      lowCount <= 16'h0;
      highCount <= 16'h0;
      lowReload <= `RST_BYTE;
      highReload <= `RST_BYTE;
      lowEvtHeld <= 1'b0;
      highEvtHeld <= 1'b0;
      lowOvfHeld <= 1'b0;
      highOvfHeld <= 1'b0;
      resetPending <= 1'b0;
      resetCycles <= 3'h0;
      chipReset <= 1'b0;
      lowTimerInterrupt <= 1'b0;
      highTimerInterrupt <= 1'b0;
      stackPointerReset <= `RST_SP;
      portLatchReset <= `RST_PORT;
    end else if (chipReset) begin
      configReg <= `RST_BYTE;
      modeReg <= `RST_BYTE;
      ctrlReg <= `RST_BYTE;
      powerReg <= `RST_BYTE;
      lowCount <= 16'h0;
      highCount <= 16'h0;
      lowReload <= `RST_BYTE;
      highReload <= `RST_BYTE;
      lowEvtHeld <= 1'b0;
      highEvtHeld <= 1'b0;
      lowOvfHeld <= 1'b0;
      highOvfHeld <= 1'b0;
      lowTimerInterrupt <= 1'b0;
      highTimerInterrupt <= 1'b0;
      stackPointerReset <= `RST_SP;
      portLatchReset <= `RST_PORT;
      if (cycleEnd) begin
        if (resetCycles == 3'h1) begin
          chipReset <= 1'b0;
        end
        resetCycles <= resetCycles - 3'h1;
      end
    end else begin
      lowCount <= next_lowCount;
      highCount <= next_highCount;
      if (state3_phase1) begin
        lowEvtHeld <= 1'b0;
        highEvtHeld <= 1'b0;
      end
      if (lowFall) begin
        lowEvtHeld <= 1'b1;
      end
      if (highFall) begin
        highEvtHeld <= 1'b1;
      end
      if (lowOvf) begin
        lowOvfHeld <= 1'b1;
      end
      if (highOvf) begin
        highOvfHeld <= 1'b1;
      end
      if (state5_phase1) begin
        lowOvfHeld <= 1'b0;
        highOvfHeld <= 1'b0;
      end
      if (wdFire) begin
        resetPending <= 1'b1;
      end
      if (resetPending & cycleEnd) begin
        resetPending <= 1'b0;
        chipReset <= 1'b1;
        resetCycles <= `WD_RESET_CYCLES;
      end
      if (apbWrite) begin
        case (paddr)
          `ADDR_CONFIG: configReg <= pwdata[7:0];
          `ADDR_MODE: modeReg <= pwdata[7:0];
          `ADDR_CTRL: ctrlReg <= pwdata[7:0];
          `ADDR_LOW_COUNT: begin
            lowCount <= pwdata[15:0];
            lowReload <= pwdata[23:16];
          end
          `ADDR_HIGH_COUNT: begin
            highCount <= pwdata[15:0];
            highReload <= pwdata[23:16];
          end
          `ADDR_POWER: powerReg <= pwdata[7:0];
          default: begin
          end
        endcase
      end
      // flags set at state5_phase1; set wins over a same-cycle write
      if (state5_phase1 & lowOvfHeld) begin
        ctrlReg[`CTRL_LOW_FLAG] <= 1'b1;
      end
      if (state5_phase1 & highOvfHeld) begin
        ctrlReg[`CTRL_HIGH_FLAG] <= 1'b1;
      end
      lowTimerInterrupt <= lowFlag;
      highTimerInterrupt <= highFlag & ~watchdog;
    end
  end
  // apb read, zero wait states
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0;
    case (paddr)
      `ADDR_CONFIG: next_prdata = {24'h0, configReg};
      `ADDR_MODE: next_prdata = {24'h0, modeReg};
      `ADDR_CTRL: next_prdata = {24'h0, ctrlReg};
      `ADDR_LOW_COUNT: next_prdata = {8'h0, lowReload, lowCount};
      `ADDR_HIGH_COUNT: next_prdata = {8'h0, highReload, highCount};
      `ADDR_POWER: next_prdata = {24'h0, powerReg};
      `ADDR_STATUS: next_prdata = {29'h0, resetPending, chipReset, highFlag};
      default: next_prdata = 32'h0;
    endcase
  end
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= next_prdata;
    end
  end
  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule // cascaded_timer_watchdog

// ==== hw/event_sampler.v ====
`timescale 1ns/1ns
`include "cascade_timer_defs.vh"
module event_sampler (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // sampling strobe
  input wire sampleStrobe,
  // external pin
  input wire pin,
  // falling edge pulse
  output reg fallEvent
);
  reg sync1;
  reg sync2;
  reg lastSample;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      lastSample <= 1'b0;
      fallEvent <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      fallEvent <= 1'b0;
      if (sampleStrobe) begin
        lastSample <= sync2;
        fallEvent <= lastSample & ~sync2;
      end
    end
  end
endmodule // event_sampler

// ==== hw/machine_cycle.v ====
`timescale 1ns/1ns
`include "cascade_timer_defs.vh"
module machine_cycle (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // phase strobes
  output wire strobeS3P1,
  output wire strobeS5P1,
  output wire strobeS5P2,
  output wire cycleEnd
);
  reg [3:0] phase;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 4'h0;
    end else if (phase == `PHASE_LAST) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end
  assign strobeS3P1 = (phase == `PHASE_STATE3_PHASE1);
  assign strobeS5P1 = (phase == `PHASE_STATE5_PHASE1);
  assign strobeS5P2 = (phase == `PHASE_STATE5_PHASE2);
  assign cycleEnd = (phase == `PHASE_LAST);
endmodule // machine_cycle

// ==== verification/cascaded_timer_watchdog_tb.sv ====
`timescale 1ns/1ns
`include "cascade_timer_defs.vh"
module cascaded_timer_watchdog_tb;
  reg clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg goLow = 1'b0, goHigh = 1'b0;
  reg [11:0] paddr = 12'h000, a;
  reg [31:0] pwdata = 32'h0, rd, lo, start;
  reg [7:0] half = 8'h0c, n;
  wire [31:0] prdata;
  wire [7:0] spRst, portRst, lowFalls;
  wire pready, chipReset, lowIn, highIn, highInt, lowInt;
  integer n_fail = 0, comparisons = 0, cyc = 0, k;
  always #5 clock = ~clock;
  cascaded_timer_watchdog u_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .lowCountInput(lowIn), .highCountInput(highIn),
    .chipReset(chipReset), .lowTimerInterrupt(lowInt), .highTimerInterrupt(highInt),
    .stackPointerReset(spRst), .portLatchReset(portRst));
  event_source u_low (.clock(clock), .go(goLow), .halfCycles(half), .pin(lowIn), .falls(lowFalls));
  event_source u_high (.clock(clock), .go(goHigh), .halfCycles(half), .pin(highIn), .falls());
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end
  function [31:0] join32(input [31:0] l, input [31:0] h);
    join32 = {h[15:0], l[15:0]};
  endfunction
  task chk(input [31:0] got, input [31:0] lo_, input [31:0] hi_);
    comparisons = comparisons + 1;
    if (^got === 1'bx || got < lo_ || got > hi_) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo_, hi_);
    end
  endtask
  task apb(input wr, input [11:0] ad, input [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdPair;
    apb(1'b0, `ADDR_LOW_COUNT, 32'h0);
    lo = rd;
    apb(1'b0, `ADDR_HIGH_COUNT, 32'h0);
    lo = join32(lo, rd);
  endtask
  initial begin
    k = $urandom(71150);
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b1, 12'h020, 32'hffffffff);
    for (a = 12'h000; a <= 12'h020; a = a + 12'h004) begin
      apb(1'b0, a, 32'h0);
      chk(rd, 32'h0, 32'h0);
    end
    $display("test reset done");
    start = 32'h0000fff0 | ($urandom & 32'h0000000f);
    apb(1'b1, `ADDR_LOW_COUNT, start);
    apb(1'b1, `ADDR_HIGH_COUNT, 32'h0);
    apb(1'b1, `ADDR_CONFIG, 32'h40);
    repeat (240) @(posedge clock);
    apb(1'b1, `ADDR_CONFIG, 32'h0);
    rdPair;
    chk(lo, start + 32'h14, start + 32'h15);
    start = lo;
    repeat (100) @(posedge clock);
    rdPair;
    chk(lo, start, start);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd & 32'h20, 32'h0, 32'h0);
    apb(1'b1, `ADDR_LOW_COUNT, 32'h0000fffe);
    apb(1'b1, `ADDR_HIGH_COUNT, 32'h0000ffff);
    apb(1'b1, `ADDR_CONFIG, 32'h40);
    repeat (60) @(posedge clock);
    apb(1'b1, `ADDR_CONFIG, 32'h0);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd & 32'ha0, 32'h80, 32'h80);
    chk({31'h0, highInt}, 32'h1, 32'h1);
    apb(1'b1, `ADDR_MODE, 32'h01);
    apb(1'b1, `ADDR_LOW_COUNT, 32'h0000fffc);
    apb(1'b1, `ADDR_CTRL, 32'h10);
    repeat (120) @(posedge clock);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd & 32'ha0, 32'h20, 32'h20);
    chk({31'h0, lowInt}, 32'h1, 32'h1);
    apb(1'b1, `ADDR_CTRL, 32'h0);
    apb(1'b0, `ADDR_LOW_COUNT, 32'h0);
    chk(rd & 32'hffff, 32'h6, 32'h7);
    $display("test cascade timer done");
    for (k = 0; k < 2; k = k + 1) begin
      apb(1'b1, `ADDR_POWER, k ? 32'h2 : 32'h0);
      apb(1'b1, `ADDR_MODE, 32'h04);
      apb(1'b1, `ADDR_LOW_COUNT, 32'h0);
      apb(1'b1, `ADDR_HIGH_COUNT, 32'h0);
      apb(1'b1, `ADDR_CONFIG, 32'h40);
      n = 8'h03 + 8'($urandom % 8);
      half <= 8'h0c + 8'($urandom % 19);
      goLow <= 1'b1;
      while (lowFalls !== n || lowIn !== 1'b1) @(posedge clock);
      goLow <= 1'b0;
      repeat (40) @(posedge clock);
      apb(1'b1, `ADDR_CONFIG, 32'h0);
      rdPair;
      chk(lo, {24'h0, n}, {24'h0, n});
    end
    apb(1'b1, `ADDR_POWER, 32'h0);
    $display("test event counter done");
    for (k = 0; k < 2; k = k + 1) begin
      half <= 8'h0c;
      apb(1'b1, `ADDR_CONFIG, 32'h80);
      apb(1'b1, `ADDR_MODE, k ? 32'h50 : 32'h10);
      apb(1'b1, `ADDR_HIGH_COUNT, 32'h0000fffe);
      apb(1'b1, `ADDR_CTRL, 32'h40);
      goHigh <= k[0];
      while (chipReset !== 1'b1) @(posedge clock);
      goHigh <= 1'b0;
      while (chipReset === 1'b1) @(posedge clock);
      for (a = 12'h000; a <= 12'h010; a = a + 12'h004) begin
        apb(1'b0, a, 32'h0);
        chk(rd, 32'h0, 32'h0);
      end
      chk({16'h0, spRst, portRst}, 32'h07ff, 32'h07ff);
    end
    $display("test watchdog done");
    apb(1'b1, `ADDR_CONFIG, 32'h80);
    apb(1'b1, `ADDR_MODE, 32'h10);
    apb(1'b1, `ADDR_CTRL, 32'h40);
    lo = 32'h0;
    repeat (3) begin
      apb(1'b1, `ADDR_HIGH_COUNT, 32'h0000ff00);
      repeat (1200) begin
        @(posedge clock);
        if (chipReset !== 1'b0) lo = lo + 32'h1;
      end
    end
    chk(lo, 32'h0, 32'h0);
    apb(1'b1, `ADDR_CONFIG, 32'h0);
    apb(1'b1, `ADDR_CTRL, 32'h0);
    $display("test watchdog reload done");
    finish_test;
  end
endmodule // cascaded_timer_watchdog_tb

// ==== verification/event_source.sv ====
`timescale 1ns/1ns
module event_source (
  // clock
  input wire clock,
  // control
  input wire go,
  input wire [7:0] halfCycles,
  // pin and falling edges sent
  output reg pin = 1'b1,
  output reg [7:0] falls = 8'h00
);
  reg [7:0] cnt = 8'h00;
  always @(posedge clock) begin
    if (!go) begin
      pin <= 1'b1;
      falls <= 8'h00;
      cnt <= 8'h00;
    end else if (cnt + 8'h01 >= (halfCycles < 8'h0c ? 8'h0c : halfCycles)) begin
      cnt <= 8'h00;
      pin <= ~pin;
      if (pin) falls <= falls + 8'h01;
    end else cnt <= cnt + 8'h01;
  end
endmodule // event_source

// ==== verification/timer_wd_sva.sv ====
`timescale 1ns/1ns
module timer_wd_sva (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // chip side
  input wire chipReset,
  input wire lowTimerInterrupt,
  input wire highTimerInterrupt,
  input wire [7:0] stackPointerReset,
  input wire [7:0] portLatchReset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  reg [6:0] hiCnt;
  // length of the current forced reset
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) hiCnt <= 7'h00;
    else if (chipReset) hiCnt <= hiCnt + 7'h01;
    else hiCnt <= 7'h00;
  end
  property p_ready; pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("apb answer late or in error");
  property p_sp; stackPointerReset == 8'h07; endproperty
  a_sp: assert property (p_sp) else $error("stack reset value wrong");
  property p_port; portLatchReset == 8'hff; endproperty
  a_port: assert property (p_port) else $error("port reset value wrong");
  property p_hole; psel && !penable && !pwrite && paddr == 12'h020 |=> prdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_hold; !(psel && !penable && !pwrite) && !chipReset |=> $stable(prdata) || chipReset;
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_wdmin; $rose(chipReset) |-> chipReset [*8]; endproperty
  a_wdmin: assert property (p_wdmin) else $error("forced reset too short");
  property p_wdlen; $fell(chipReset) |-> hiCnt >= 7'h3b && hiCnt <= 7'h3d; endproperty
  a_wdlen: assert property (p_wdlen) else $error("forced reset not five cycles");
  property p_flags; $rose(chipReset) |=> !lowTimerInterrupt && !highTimerInterrupt; endproperty
  a_flags: assert property (p_flags) else $error("flags survive forced reset");
endmodule // timer_wd_sva
bind cascaded_timer_watchdog timer_wd_sva u_sva (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chipReset(chipReset), .lowTimerInterrupt(lowTimerInterrupt),
  .highTimerInterrupt(highTimerInterrupt), .stackPointerReset(stackPointerReset),
  .portLatchReset(portLatchReset));
